/* pkg/hyp_csr_pkg.sv */
// Constants shared by the hypervisor guest CSR bank.
// Operation
// (R1) Counter gate: 32 bits, one per counter.
// (R2) Clear gate under virtualization raises virtual-instruction; code raises it only when the machine gate bit is also set.
// (R3) Set gate permits guest counter reads.
// (R4) Virtual user needs both gate bits.
// (R5) Gate always exists; bits may read zero.
// (R6) Guest time is modular sum with offset.
// (R7) Upper offset half exists only at 32 bits.
// (R8) Trap value: shifted address on guest fault.
// (R9) Implicit walk faults record walk address.
// (R10) Misaligned faults record faulting portion's address.
// (R11) 32-bit trap value holds address bits 33:2.
// (R12) Trap value holds zero, maybe a subset.
// (R13) Trap instruction written on every trap.
// (R14) Trap-virtual-memory makes root access illegal; code refuses it only from HS mode and allows it from M.
// (R15) 64-bit root layout: mode, identifier, page.
// (R16) 64-bit mode encodings 0, 8, 9, 10.
// (R17) 32-bit mode encodings 0 and 1.
// (R18) Software zeroes other fields in bare mode.
// (R19) Unsupported mode: each field legalised separately.
// (R20) Two lowest root page bits read zero.
// (R21) Identifier implemented from bit zero upward.
// (R22) Root active unless user mode and control 0.
package hyp_csr_pkg;
	// Register indices on the plain register port.
	localparam logic [3:0] IDX_GATE = 4'h0;
	localparam logic [3:0] IDX_TDELTA = 4'h1;
	localparam logic [3:0] IDX_TDELTAH = 4'h2;
	localparam logic [3:0] IDX_TVAL = 4'h3;
	localparam logic [3:0] IDX_TINST = 4'h4;
	localparam logic [3:0] IDX_GATP = 4'h5;
	// Counter gate bit positions.
	localparam int CYCLE_GATE_BIT = 0;
	localparam int TIMER_GATE_BIT = 1;
	localparam int RETIRED_GATE_BIT = 2;
	// Root layout at 64 bits.
	localparam int MODE64_LSB = 60;
	localparam int IDENT64_LSB = 44;
	localparam int RPAGE64_W = 44;
	// Root layout at 32 bits.
	localparam int MODE32_BIT = 31;
	localparam int IDENT32_LSB = 22;
	localparam int IDENT32_W = 9;
	localparam int RPAGE32_W = 22;
	// Identifier width limits per scheme.
	localparam int IDENT_LIMIT64 = 14;
	localparam int IDENT_LIMIT32 = 7;
	// Mode encodings.
	localparam logic [3:0] MODE_BARE = 4'h0;
	localparam logic [3:0] MODE_PAGED34 = 4'h1;
	localparam logic [3:0] MODE_PAGED41 = 4'h8;
	localparam logic [3:0] MODE_PAGED50 = 4'h9;
	localparam logic [3:0] MODE_PAGED59 = 4'hA;
	// Privilege encodings.
	localparam logic [1:0] PRIV_U = 2'h0;
	localparam logic [1:0] PRIV_S = 2'h1;
	// Values after reset.
	localparam logic [31:0] GATE_RESET = 32'h0000_0000;
	localparam logic [63:0] WIDE_RESET = 64'h0000_0000_0000_0000;
	localparam logic [3:0] MODE_RESET = 4'h0;
	// Shift applied to a guest physical address.
	localparam int GPA_SHIFT = 2;
endpackage : hyp_csr_pkg

/* pkg/ctr_gate_if.sv */
// Interface carrying one counter-read permission query and its answer.
`timescale 1ns/1ps
interface ctr_gate_if;
	logic [4:0] idx; // Counter number.
	logic virt; // Virtualization active.
	logic vu; // Virtual user mode.
	logic [31:0] m_gate; // Machine counter gate.
	logic [31:0] s_gate; // Supervisor counter gate.
	logic [31:0] h_gate; // Guest counter gate.
	logic virt_exc; // Read raises virtual-instruction exception.
	logic gate_ok; // Read passes the guest gates.
	modport chk (input idx, virt, vu, m_gate, s_gate, h_gate,
		output virt_exc, gate_ok);
	modport req (output idx, virt, vu, m_gate, s_gate, h_gate,
		input virt_exc, gate_ok);
endinterface : ctr_gate_if

/* src/ctr_gate_check.sv */
// Combinational check of a counter read against the three counter gates.
`timescale 1ns/1ps
module ctr_gate_check (
	ctr_gate_if.chk q
);
	// Gate bits that apply to the requested counter.
	wire m_bit = q.m_gate[q.idx];
	wire h_bit = q.h_gate[q.idx];
	wire s_bit = q.s_gate[q.idx];
	// In virtual user mode the supervisor gate must also be set.
	wire vu_block = q.vu & ~s_bit; // [R4]
	// A clear guest gate traps only when machine level grants the counter.
	assign q.virt_exc = q.virt & m_bit & (~h_bit | vu_block); // [R2] [R4]
	// Outside virtualization the guest gates do not apply.
	assign q.gate_ok = ~q.virt | (h_bit & ~vu_block); // [R3]
endmodule : ctr_gate_check

/* src/hypervisor_guest_csrs.sv */
// Hypervisor guest CSR bank: counter gate, time offset, trap records, root.
`timescale 1ns/1ps
module hypervisor_guest_csrs #(
	parameter int XLEN = 64, // Register width, 32 or 64.
	parameter logic [31:0] GATE_MASK = 32'hFFFF_FFFF, // Implemented gates.
	parameter logic [63:0] TVAL_MASK = 64'hFFFF_FFFF_FFFF_FFFF, // Held bits.
	parameter logic [15:0] MODES_OK = 16'h0701, // Supported modes.
	parameter int IDENT_WIDTH = 14 // Implemented identifier bits.
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [3:0] i_addr,
	input wire logic [XLEN-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [XLEN-1:0] o_rdata,
	output logic o_csr_illegal,
	input wire logic [1:0] i_priv,
	input wire logic i_virt,
	input wire logic i_trap_virtual_memory_control,
	input wire logic i_hypervisor_user_access_control,
	input wire logic [31:0] i_mcounteren,
	input wire logic [31:0] i_scounteren,
	input wire logic i_ctr_rd,
	input wire logic [4:0] i_ctr_idx,
	output logic o_ctr_virt_exc,
	output logic o_ctr_gate_ok,
	input wire logic [63:0] i_time,
	output logic [63:0] o_time_rd,
	input wire logic i_trap_hs,
	input wire logic i_trap_guest_fault,
	input wire logic [XLEN+1:0] i_trap_gpa,
	input wire logic [XLEN-1:0] i_trap_inst,
	output logic [3:0] o_gstage_mode,
	output logic [13:0] o_virtual_machine_identifier,
	output logic [43:0] o_root_page_number,
	output logic o_gstage_active
);
	// Width selection and derived masks.
	localparam bit IS64 = (XLEN == 64);
	localparam logic [13:0] IDENT_MASK = 14'((32'h1 << IDENT_WIDTH) - 32'h1);

	// Stored state.
	logic [31:0] gate_reg, gate_next; // Guest counter gate.
	logic [63:0] delta_reg, delta_next; // Guest time offset.
	logic [63:0] tval_reg, tval_next; // Hypervisor trap value.
	logic [63:0] tinst_reg, tinst_next; // Hypervisor trap instruction.
	logic [3:0] mode_reg, mode_next; // Translation mode.
	logic [13:0] ident_reg, ident_next; // Identifier.
	logic [43:0] rpage_reg, rpage_next; // Root page number.
	logic [XLEN-1:0] rdata_reg; // Read answer.
	logic illegal_reg; // Illegal access flag.
	logic [63:0] time_reg; // Time as the current mode reads it.
	logic exc_reg, ok_reg; // Counter check answers.

	// Software write data widened to 64 bits.
	wire [63:0] wd64 = 64'(i_wdata);
	// Hypervisor-supervisor mode means supervisor level without virt.
	wire hs_mode = (i_priv == hyp_csr_pkg::PRIV_S) & ~i_virt;
	// Access to the root from HS mode is refused under trap-virtual-memory.
	wire gatp_sel = (i_addr == hyp_csr_pkg::IDX_GATP);
	wire gatp_trap = gatp_sel & hs_mode & i_trap_virtual_memory_control; // [R14]
	// The upper offset half does not exist at 64 bits.
	wire dh_sel = (i_addr == hyp_csr_pkg::IDX_TDELTAH);
	wire dh_gone = dh_sel & IS64; // [R7]
	wire bad = gatp_trap | dh_gone;
	wire wr_ok = i_wr & ~bad;
	wire rd_ok = i_rd & ~bad;

	// Per-register write strobes.
	wire wr_gate = wr_ok & (i_addr == hyp_csr_pkg::IDX_GATE);
	wire wr_dl = wr_ok & (i_addr == hyp_csr_pkg::IDX_TDELTA);
	wire wr_dh = wr_ok & dh_sel;
	wire wr_tval = wr_ok & (i_addr == hyp_csr_pkg::IDX_TVAL);
	wire wr_tinst = wr_ok & (i_addr == hyp_csr_pkg::IDX_TINST);
	wire wr_gatp = wr_ok & gatp_sel;

	// Root fields extracted from the write data for either layout.
	wire [3:0] w_mode = IS64 ? wd64[63:60] : {3'h0, wd64[31]}; // [R15] [R17]
	wire [13:0] w_ident = IS64 ? wd64[57:44] : {5'h0, wd64[30:22]};
	wire [43:0] w_rpage = IS64 ? wd64[43:0] : {22'h0, wd64[21:0]};
	// Per-field legalisation; an unsupported mode keeps the old mode only.
	wire [3:0] l_mode = MODES_OK[w_mode] ? w_mode : mode_reg; // [R16] [R19]
	wire [13:0] l_ident = w_ident & IDENT_MASK; // [R21]
	wire [43:0] l_rpage = {w_rpage[43:2], 2'h0}; // [R20]

	// Guest fault address with the shift; other traps record zero.
	wire [63:0] gpa_shift = 64'(i_trap_gpa[XLEN+1:hyp_csr_pkg::GPA_SHIFT]);
	wire [63:0] trap_tval = i_trap_guest_fault ?
		(gpa_shift & TVAL_MASK) : 64'h0; // [R8] [R9] [R10] [R11] [R12]

	// Next values: a trap wins over a software write in the same cycle.
	assign gate_next = wr_gate ? (wd64[31:0] & GATE_MASK) : gate_reg; // [R1] [R5]
	assign delta_next = wr_dh ? {wd64[31:0], delta_reg[31:0]} :
		wr_dl ? (IS64 ? wd64 : {delta_reg[63:32], wd64[31:0]}) :
		delta_reg; // [R7]
	assign tval_next = i_trap_hs ? trap_tval :
		wr_tval ? (wd64 & TVAL_MASK) : tval_reg; // [R8] [R12]
	assign tinst_next = i_trap_hs ? 64'(i_trap_inst) :
		wr_tinst ? wd64 : tinst_reg; // [R13]
	assign mode_next = wr_gatp ? l_mode : mode_reg;
	assign ident_next = wr_gatp ? l_ident : ident_reg;
	assign rpage_next = wr_gatp ? l_rpage : rpage_reg;

	// Root read back in the layout of the configured width.
	wire [63:0] gatp_rd = IS64 ?
		{mode_reg, 2'h0, ident_reg, rpage_reg} :
		{32'h0, mode_reg[0], ident_reg[8:0], rpage_reg[21:0]}; // [R15] [R17]

	// Read multiplexer; unmapped or refused reads answer zero.
	logic [63:0] rd64;
	always_comb begin
		case (i_addr)
			hyp_csr_pkg::IDX_GATE: begin
				rd64 = {32'h0, gate_reg};
			end
			hyp_csr_pkg::IDX_TDELTA: begin
				rd64 = IS64 ? delta_reg : {32'h0, delta_reg[31:0]};
			end
			hyp_csr_pkg::IDX_TDELTAH: begin
				rd64 = {32'h0, delta_reg[63:32]};
			end
			hyp_csr_pkg::IDX_TVAL: begin
				rd64 = tval_reg;
			end
			hyp_csr_pkg::IDX_TINST: begin
				rd64 = tinst_reg;
			end
			hyp_csr_pkg::IDX_GATP: begin
				rd64 = gatp_rd;
			end
			default: begin
				rd64 = 64'h0;
			end
		endcase
	end

	// Guest time: modular sum, carry out of bit 63 dropped.
	wire guest_view = i_virt &
		((i_priv == hyp_csr_pkg::PRIV_S) | (i_priv == hyp_csr_pkg::PRIV_U));
	wire [63:0] time_sum = i_time + delta_reg; // [R6]
	wire [63:0] time_next = guest_view ? time_sum : i_time;

	// Counter-read permission query.
	ctr_gate_if cq ();
	assign cq.idx = i_ctr_idx;
	assign cq.virt = i_virt;
	assign cq.vu = i_virt & (i_priv == hyp_csr_pkg::PRIV_U);
	assign cq.m_gate = i_mcounteren;
	assign cq.s_gate = i_scounteren;
	assign cq.h_gate = gate_reg;
	ctr_gate_check u_chk (
		.q(cq)
	);

	// Architectural registers.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			gate_reg <= hyp_csr_pkg::GATE_RESET;
			delta_reg <= hyp_csr_pkg::WIDE_RESET;
			tval_reg <= hyp_csr_pkg::WIDE_RESET;
			tinst_reg <= hyp_csr_pkg::WIDE_RESET;
			mode_reg <= hyp_csr_pkg::MODE_RESET;
			ident_reg <= 14'h0000;
			rpage_reg <= 44'h000_0000_0000;
		end else begin
			gate_reg <= gate_next;
			delta_reg <= delta_next;
			tval_reg <= tval_next;
			tinst_reg <= tinst_next;
			mode_reg <= mode_next;
			ident_reg <= ident_next;
			rpage_reg <= rpage_next;
		end
	end

	// Read answer and illegal flag stand one cycle after the strobe.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			rdata_reg <= '0;
			illegal_reg <= 1'b0;
		end else begin
			rdata_reg <= rd_ok ? rd64[XLEN-1:0] : '0;
			illegal_reg <= (i_rd | i_wr) & bad; // [R14]
		end
	end

	// Time and counter answers registered one cycle after their inputs.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			time_reg <= 64'h0;
			exc_reg <= 1'b0;
			ok_reg <= 1'b0;
		end else begin
			time_reg <= time_next;
			exc_reg <= i_ctr_rd & cq.virt_exc; // [R2]
			ok_reg <= i_ctr_rd & cq.gate_ok; // [R3]
		end
	end

	// Outputs.
	assign o_rdata = rdata_reg;
	assign o_csr_illegal = illegal_reg;
	assign o_time_rd = time_reg;
	assign o_ctr_virt_exc = exc_reg;
	assign o_ctr_gate_ok = ok_reg;
	assign o_gstage_mode = mode_reg;
	assign o_virtual_machine_identifier = ident_reg;
	assign o_root_page_number = rpage_reg;
	// Root inactive only for user mode with the access control clear.
	assign o_gstage_active = ~((i_priv == hyp_csr_pkg::PRIV_U) &
		~i_hypervisor_user_access_control); // [R22]

	// Checks on the bank's own behaviour.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	// A trap into supervisor level, with and without a guest fault.
	sequence seq_fault_trap;
		i_trap_hs && i_trap_guest_fault;
	endsequence
	sequence seq_other_trap;
		i_trap_hs && !i_trap_guest_fault;
	endsequence
	// A refused root access under trap-virtual-memory.
	sequence seq_root_refused;
		i_rd && gatp_sel && hs_mode && i_trap_virtual_memory_control;
	endsequence

	AST_TVAL_OTHER: assert property ( // [R8]
		seq_other_trap |=> tval_reg == 64'h0)
		else $error("trap value not zero after other trap");
	AST_TVAL_FAULT: assert property ( // [R11]
		seq_fault_trap |=> tval_reg ==
		(64'($past(i_trap_gpa) >> 2) & TVAL_MASK))
		else $error("trap value not shifted fault address");
	AST_TINST: assert property ( // [R13]
		i_trap_hs |=> tinst_reg == 64'($past(i_trap_inst)))
		else $error("trap instruction not recorded");
	AST_TIME_SUM: assert property ( // [R6]
		guest_view |=> o_time_rd == $past(i_time) + $past(delta_reg))
		else $error("guest time not offset");
	AST_CTR_TRAP: assert property ( // [R2]
		i_ctr_rd && i_virt && i_mcounteren[i_ctr_idx] &&
		!gate_reg[i_ctr_idx] |=> o_ctr_virt_exc && !o_ctr_gate_ok)
		else $error("cleared gate did not trap");
	AST_CTR_PASS: assert property ( // [R3]
		i_ctr_rd && i_virt && i_priv == hyp_csr_pkg::PRIV_S &&
		gate_reg[i_ctr_idx] |=> o_ctr_gate_ok && !o_ctr_virt_exc)
		else $error("set gate did not permit read");
	AST_CTR_VU: assert property ( // [R4]
		i_ctr_rd && i_virt && i_priv == hyp_csr_pkg::PRIV_U &&
		!i_scounteren[i_ctr_idx] |=> !o_ctr_gate_ok)
		else $error("virtual user read passed without both gates");
	AST_ROOT_REFUSED: assert property ( // [R14]
		seq_root_refused |=> o_csr_illegal && o_rdata == '0)
		else $error("root access not refused");
	AST_RPAGE_LOW: assert property ( // [R20]
		rpage_reg[1:0] == 2'h0)
		else $error("root page low bits not zero");
	AST_IDENT_MASK: assert property ( // [R21]
		(ident_reg & ~IDENT_MASK) == 14'h0)
		else $error("unimplemented identifier bits set");
	AST_MODE_LEGAL: assert property ( // [R19]
		wr_gatp && !MODES_OK[w_mode] |=> mode_reg == $past(mode_reg) &&
		ident_reg == $past(l_ident))
		else $error("unsupported mode write mishandled");
	AST_GATE_MASK: assert property ( // [R5]
		(gate_reg & ~GATE_MASK) == 32'h0)
		else $error("hardwired gate bit set");
endmodule : hypervisor_guest_csrs

/* testbench/hypervisor_guest_csrs_tb.sv */
// Self-checking bench for the hypervisor guest CSR bank.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
n_mismatch++; $display("Error %s exp %h got %h", nm, e, g); end end
module hypervisor_guest_csrs_tb;
	localparam logic [15:0] OK_MODES = 16'h0701; // Supported modes.
	// Two gate bits are hardwired to zero so that their reads trap under virtualization whenever the machine gate grants them.
	localparam logic [31:0] GMASK = 32'h7FFF_FFF7;
	logic i_clk = 1'b0; // Bench clock.
	logic i_srst = 1'b1; // Synchronous reset.
	logic [3:0] i_addr = 4'h0; // Register index.
	logic [63:0] i_wdata = 64'h0; // Write data.
	logic i_wr = 1'b0; // Write strobe.
	logic i_rd = 1'b0; // Read strobe.
	logic [63:0] o_rdata; // Read data.
	logic o_csr_illegal; // Refused access flag.
	logic [1:0] i_priv = 2'h3; // Privilege level.
	logic i_virt = 1'b0; // Virtualization active.
	logic vm_trap = 1'b0; // Trap-virtual-memory control.
	logic huc = 1'b0; // Hypervisor-user access control.
	logic [31:0] mce = 32'h0; // Machine counter gate.
	logic [31:0] sce = 32'h0; // Supervisor counter gate.
	logic ctr_rd = 1'b0; // Counter read query.
	logic [4:0] ctr_idx = 5'h0; // Counter number.
	logic o_ctr_virt_exc; // Query raised an exception.
	logic o_ctr_gate_ok; // Query passed the gates.
	logic [63:0] i_time = 64'h0; // True time.
	logic [63:0] o_time_rd; // Time as seen by the reader.
	logic trap = 1'b0; // Trap into HS.
	logic gfault = 1'b0; // Trap is a guest page fault.
	logic [65:0] gpa = 66'h0; // Faulting guest address.
	logic [63:0] tinst = 64'h0; // Trap instruction value.
	logic [3:0] o_gstage_mode; // Root mode field.
	logic [13:0] o_virtual_machine_identifier; // Root identifier.
	logic [43:0] o_root_page_number; // Root page field.
	logic o_gstage_active; // Root in use.
	int n_mismatch = 0; // Mismatches seen.
	int checked = 0; // Comparisons made.
	int rv; // Seed result.
	logic [63:0] rdat; // Last read data.
	logic ill; // Last refusal flag.
	logic [31:0] g; // Model of the guest counter gate.
	logic [63:0] offs; // Model of the time offset.
	logic [63:0] root; // Model of the root register.
	logic [3:0] mode; // Model of the root mode.
	logic [13:0] vm; // Identifier stimulus.
	logic [43:0] pp; // Page stimulus.
	logic vu; // Virtual user mode.
	logic [4:0] b; // Counter number under test.
	logic ex; // Expected exception answer.
	logic okx; // Expected pass answer.

	hypervisor_guest_csrs #(.MODES_OK(OK_MODES), .GATE_MASK(GMASK)) dut_u (
		.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_csr_illegal(o_csr_illegal), .i_priv(i_priv), .i_virt(i_virt),
		.i_trap_virtual_memory_control(vm_trap),
		.i_hypervisor_user_access_control(huc),
		.i_mcounteren(mce), .i_scounteren(sce), .i_ctr_rd(ctr_rd),
		.i_ctr_idx(ctr_idx), .o_ctr_virt_exc(o_ctr_virt_exc),
		.o_ctr_gate_ok(o_ctr_gate_ok), .i_time(i_time),
		.o_time_rd(o_time_rd), .i_trap_hs(trap),
		.i_trap_guest_fault(gfault), .i_trap_gpa(gpa),
		.i_trap_inst(tinst), .o_gstage_mode(o_gstage_mode),
		.o_virtual_machine_identifier(o_virtual_machine_identifier),
		.o_root_page_number(o_root_page_number),
		.o_gstage_active(o_gstage_active));

	// Free-running 100 MHz clock.
	always #5 i_clk = ~i_clk;

	// One register access; the answer is taken in the cycle after it.
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [63:0] d);
		@(posedge i_clk);
		i_wr <= w;
		i_rd <= ~w;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		#1;
		rdat = o_rdata;
		ill = o_csr_illegal;
	endtask : bus

	// Reads a register and compares data and refusal flag.
	task automatic rchk(input logic [3:0] a, input logic [63:0] e,
		input logic il);
		bus(1'b0, a, 64'h0);
		`CHK("rdata", e, rdat)
		`CHK("illegal", il, ill)
	endtask : rchk

	// Prints the counts and the verdict, then stops.
	task automatic test_done();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done

	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge i_clk);
		n_mismatch++;
		$display("Error watchdog exp 0 got 1");
		test_done();
	end

	// Main sequence.
	initial begin
		rv = $urandom(99925);
		repeat (10) @(posedge i_clk);
		i_srst <= 1'b0;
		// All registers start at zero; the upper offset half is absent.
		for (int k = 0; k < 6; k++) begin
			if (k != 2) rchk(k[3:0], 64'h0, 1'b0);
		end
		rchk(4'h2, 64'h0, 1'b1);
		bus(1'b1, 4'h2, 64'hFFFF_FFFF_FFFF_FFFF);
		`CHK("wr_upper", 1'b1, ill)
		rchk(4'h1, 64'h0, 1'b0);
		rchk(4'h9, 64'h0, 1'b0);
		// Random gates and modes against the counter query.
		for (int k = 0; k < 40; k++) begin
			g = $urandom;
			bus(1'b1, 4'h0, {32'h0, g});
			// Hardwired gate bits read back as zero.
			g = g & GMASK;
			rchk(4'h0, {32'h0, g}, 1'b0);
			@(posedge i_clk);
			i_virt <= 1'($urandom);
			i_priv <= ($urandom % 2) ? hyp_csr_pkg::PRIV_U
				: hyp_csr_pkg::PRIV_S;
			mce <= $urandom;
			sce <= $urandom;
			ctr_idx <= 5'($urandom);
			ctr_rd <= 1'b1;
			@(posedge i_clk);
			ctr_rd <= 1'b0;
			#1;
			b = ctr_idx;
			vu = i_virt & (i_priv == hyp_csr_pkg::PRIV_U);
			ex = i_virt & mce[b] & (~g[b] | (vu & ~sce[b]));
			okx = ~i_virt | (g[b] & (~vu | sce[b]));
			`CHK("exc", ex, o_ctr_virt_exc)
			`CHK("ok", okx, o_ctr_gate_ok)
		end
		// Guest time is the wrapped sum; a large offset acts negative.
		offs = {$urandom, $urandom} | 64'h8000_0000_0000_0000;
		bus(1'b1, 4'h1, offs);
		rchk(4'h1, offs, 1'b0);
		for (int k = 0; k < 3; k++) begin
			@(posedge i_clk);
			i_virt <= (k != 2);
			i_priv <= (k == 1) ? hyp_csr_pkg::PRIV_U : hyp_csr_pkg::PRIV_S;
			i_time <= {$urandom, $urandom};
			@(posedge i_clk);
			#1;
			`CHK("time", i_virt ? i_time + offs : i_time, o_time_rd)
		end
		// Traps record the shifted address on faults, zero otherwise.
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clk);
			trap <= 1'b1;
			gfault <= k[0];
			gpa <= 66'({$urandom, $urandom, $urandom});
			tinst <= {$urandom, $urandom};
			@(posedge i_clk);
			trap <= 1'b0;
			rchk(4'h3, gfault ? gpa[65:2] : 64'h0, 1'b0);
			rchk(4'h4, tinst, 1'b0);
		end
		bus(1'b1, 4'h3, 64'h0);
		rchk(4'h3, 64'h0, 1'b0);
		// Root: every mode value, unsupported ones keep the old mode.
		@(posedge i_clk);
		i_virt <= 1'b0;
		i_priv <= hyp_csr_pkg::PRIV_S;
		mode = 4'h0;
		for (int k = 0; k < 16; k++) begin
			vm = 14'($urandom);
			pp = 44'({$urandom, $urandom});
			if (OK_MODES[k]) mode = k[3:0];
			// Software selecting bare mode zeroes every other field.
			if (k == 0) begin
				vm = 14'h0000;
				pp = 44'h000_0000_0000;
			end
			root = {mode, 2'b00, vm, pp[43:2], 2'b00};
			bus(1'b1, 4'h5, {k[3:0], (k == 0) ? 2'b00 : 2'b11, vm, pp});
			rchk(4'h5, root, 1'b0);
			`CHK("mode", mode, o_gstage_mode)
			`CHK("ident", vm, o_virtual_machine_identifier)
			`CHK("page", {pp[43:2], 2'b00}, o_root_page_number)
		end
		// Root refused from HS while trapping is on, allowed from M.
		@(posedge i_clk);
		vm_trap <= 1'b1;
		bus(1'b1, 4'h5, 64'h0);
		`CHK("wr_root", 1'b1, ill)
		rchk(4'h5, 64'h0, 1'b1);
		@(posedge i_clk);
		i_priv <= 2'h3;
		rchk(4'h5, root, 1'b0);
		@(posedge i_clk);
		vm_trap <= 1'b0;
		bus(1'b1, 4'h5, 64'h0);
		rchk(4'h5, 64'h0, 1'b0);
		// Root activity against privilege and user access control.
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clk);
			i_priv <= k[1] ? hyp_csr_pkg::PRIV_S : hyp_csr_pkg::PRIV_U;
			huc <= k[0];
			@(posedge i_clk);
			#1;
			`CHK("active", k[1] | k[0], o_gstage_active)
		end
		test_done();
	end
endmodule : hypervisor_guest_csrs_tb
